// ==== rtl/fsr_top.sv ====
// Fault status readback: serial shift register, latches, status holder, AXI4-Lite slave
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
module fsr_top (
    input  wire logic                 core_clk,      // 40 MHz core clock
    input  wire logic                 rst_n,         // Async reset, active low
    input  wire fsr_pkg::fsr_pins_type pins,         // Serial link pins, async
    input  wire fsr_pkg::fsr_det_type  det,          // Detector results, async
    output logic                      serial_out,    // Serial data out
    output logic [15:0]               channel_output, // On-off latch to drivers
    output logic                      short_threshold_select, // Short threshold choice
    input  wire logic [7:0]           s_axi_awaddr,  // Write address
    input  wire logic                 s_axi_awvalid, // Write address valid
    output logic                      s_axi_awready, // Write address ready
    input  wire logic [31:0]          s_axi_wdata,   // Write data
    input  wire logic [3:0]           s_axi_wstrb,   // Write strobes
    input  wire logic                 s_axi_wvalid,  // Write data valid
    output logic                      s_axi_wready,  // Write data ready
    output logic [1:0]                s_axi_bresp,   // Write response
    output logic                      s_axi_bvalid,  // Write response valid
    input  wire logic                 s_axi_bready,  // Write response ready
    input  wire logic [7:0]           s_axi_araddr,  // Read address
    input  wire logic                 s_axi_arvalid, // Read address valid
    output logic                      s_axi_arready, // Read address ready
    output logic [31:0]               s_axi_rdata,   // Read data
    output logic [1:0]                s_axi_rresp,   // Read response
    output logic                      s_axi_rvalid,  // Read data valid
    input  wire logic                 s_axi_rready   // Read data ready
);
    import fsr_pkg::*;

    // ***************************************************
    // Reset and input synchronisers
    // ***************************************************
    logic [1:0]   rst_sync_r;
    logic         rst_core_n;
    fsr_pins_type pin_s1_r;
    fsr_pins_type pin_s2_r;
    fsr_pins_type pin_d_r;
    fsr_det_type  det_s1_r;
    fsr_det_type  det_s2_r;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_r[1];

    // Two-flop synchronisers plus edge-detect delay stage
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_d_r  <= '0;
            det_s1_r <= '0;
            det_s2_r <= '0;
        end else begin
            pin_s1_r <= pins;
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
            det_s1_r <= det;
            det_s2_r <= det_s1_r;
        end
    end

    logic sclk_rise;
    logic lat_rise;
    logic blank_rise;
    logic blank_fall;
    assign sclk_rise  = pin_s2_r.sclk & ~pin_d_r.sclk;
    assign lat_rise   = pin_s2_r.lat & ~pin_d_r.lat;
    assign blank_rise = pin_s2_r.blank & ~pin_d_r.blank;
    assign blank_fall = ~pin_s2_r.blank & pin_d_r.blank;

    // ***************************************************
    // Latches, shift register and status selection
    // ***************************************************
    logic [15:0] shreg_r;
    logic [15:0] onoff_r;
    logic [15:0] ctrl_lat_r;
    logic [15:0] holder_r;
    logic        new_data_r;
    logic        cfg_idm_en_r;
    logic [15:0] cfg_idm_cyc_r;
    logic [1:0]  load_sel;
    logic        lat_take;
    logic        lat_data;
    logic        load_go;
    logic        capture;
    logic [15:0] sel_word;

    assign load_sel = ctrl_lat_r[CL_SEL_LO +: 2];
    assign lat_take = lat_rise & new_data_r & ~sclk_rise;
    assign lat_data = lat_take & ~pin_s2_r.sclk;
    assign load_go  = lat_data & ~shreg_r[15] & (load_sel != SEL_NONE);

    // Selected detector word with masking and global overrides
    always_comb begin
        sel_word = holder_r;
        unique case (load_sel)
            SEL_NONE:  sel_word = holder_r;
            SEL_OPEN:  sel_word = det_s2_r.thermal_shutdown ? ALL_ONES
                                : (det_s2_r.open_led_flag & onoff_r);
            SEL_SHORT: sel_word = det_s2_r.thermal_warning_flag ? ALL_ONES
                                : (det_s2_r.shorted_led_flag & onoff_r);
            SEL_LEAK:  sel_word = det_s2_r.ref_pin_short_flag ? ALL_ONES
                                : (det_s2_r.leakage_flag & ~onoff_r & {16{~cfg_idm_en_r}});
        endcase
    end

    // Common shift register: shift in or status load
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            shreg_r <= 16'h0000;
        end else if (sclk_rise) begin
            shreg_r <= {shreg_r[14:0], pin_s2_r.serial_in};
        end else if (load_go) begin
            shreg_r <= holder_r;
        end
    end
    assign serial_out = shreg_r[15];

    // Fresh shifted data flag; a shift in the same cycle wins
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            new_data_r <= 1'b0;
        end else begin
            new_data_r <= sclk_rise | (new_data_r & ~lat_take);
        end
    end

    // On-off and control data latches
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            onoff_r    <= ONOFF_RST;
            ctrl_lat_r <= CTRL_LAT_RST;
        end else if (lat_take & pin_s2_r.sclk) begin
            ctrl_lat_r <= shreg_r;
        end else if (lat_data) begin
            onoff_r    <= shreg_r;
        end
    end
    assign channel_output         = onoff_r;
    assign short_threshold_select = ctrl_lat_r[CL_THR_BIT];

    // ***************************************************
    // Invisible detection timer and status holder
    // ***************************************************
    fsr_idm_type idm_st_r;
    logic [15:0] idm_cnt_r;
    logic        idm_end;
    assign idm_end = (idm_st_r == IDM_RUN) & ~blank_rise & (idm_cnt_r >= cfg_idm_cyc_r - 16'h0001);
    assign capture = (blank_rise | idm_end) & (load_sel != SEL_NONE);

    // Working time runs from blank fall
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            idm_st_r  <= IDM_IDLE;
            idm_cnt_r <= 16'h0000;
        end else begin
            unique case (idm_st_r)
                IDM_IDLE: begin
                    idm_cnt_r <= 16'h0000;
                    if (blank_fall & cfg_idm_en_r) begin
                        idm_st_r <= IDM_RUN;
                    end
                end
                IDM_RUN: begin
                    idm_cnt_r <= idm_cnt_r + 16'h0001;
                    if (blank_rise | idm_end) begin
                        idm_st_r <= IDM_IDLE;
                    end
                end
                default: idm_st_r <= IDM_IDLE;
            endcase
        end
    end

    // Holder only changes on a capture event
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            holder_r <= 16'h0000;
        end else if (capture) begin
            holder_r <= sel_word;
        end
    end

    // ***************************************************
    // AXI4-Lite slave
    // ***************************************************
    logic       aw_have_r;
    logic       w_have_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic       wr_go;
    logic       cfg_hit;
    assign wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign cfg_hit = (awaddr_r == REG_CFG);

    // Address and data captured in either order
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_r      <= {s_axi_awaddr[7:2], 2'h0};
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response and configuration register
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            cfg_idm_en_r  <= 1'b0;
            cfg_idm_cyc_r <= IDM_CYC_RST;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= cfg_hit ? RESP_OKAY : RESP_SLVERR;
            if (cfg_hit & wstrb_r[0]) begin
                cfg_idm_cyc_r[7:0] <= wdata_r[7:0];
            end
            if (cfg_hit & wstrb_r[1]) begin
                cfg_idm_cyc_r[15:8] <= wdata_r[15:8];
            end
            if (cfg_hit & wstrb_r[2]) begin
                cfg_idm_en_r <= wdata_r[CFG_IDM_BIT];
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: answer one cycle after address
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'h0})
                REG_CFG:   s_axi_rdata <= {15'h0000, cfg_idm_en_r, cfg_idm_cyc_r};
                REG_SHIFT: s_axi_rdata <= {holder_r, shreg_r};
                REG_LATCH: s_axi_rdata <= {ctrl_lat_r, onoff_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ***************************************************
    // Assertions
    // ***************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_core_n);

    // Latch, shift and holder behaviour, checked one cycle after the triggering event
    shift_in_lsb_a: assert property (sclk_rise |=> shreg_r == {$past(shreg_r[14:0]), $past(pin_s2_r.serial_in)})
        else $error("shift register did not shift serial input");
    serial_out_advance_a: assert property (sclk_rise |=> serial_out == $past(shreg_r[14]))
        else $error("serial output did not advance");
    load_word_a: assert property (load_go |=> shreg_r == $past(holder_r))
        else $error("status word not loaded");
    onoff_copy_a: assert property (lat_data |=> onoff_r == $past(shreg_r))
        else $error("on-off latch not copied");
    msb_keep_a: assert property (lat_data && shreg_r[15] |=> $stable(shreg_r))
        else $error("status loaded with MSB set");
    stale_ignore_a: assert property (lat_rise && !new_data_r && !sclk_rise
                                     |=> $stable(shreg_r) && $stable(onoff_r) && $stable(ctrl_lat_r))
        else $error("latch pulse without new data acted");
    no_select_a: assert property (lat_rise && load_sel == SEL_NONE && !sclk_rise |=> $stable(shreg_r))
        else $error("select none changed shift register");
    open_ones_a: assert property (capture && load_sel == SEL_OPEN && det_s2_r.thermal_shutdown
                                  |=> holder_r == ALL_ONES)
        else $error("thermal shutdown did not force ones");
    short_mask_a: assert property (capture && load_sel == SEL_SHORT && !det_s2_r.thermal_warning_flag
                                   |=> holder_r == ($past(det_s2_r.shorted_led_flag) & $past(onoff_r)))
        else $error("short result not masked by on-off");
    leak_ones_a: assert property (capture && load_sel == SEL_LEAK && det_s2_r.ref_pin_short_flag
                                  |=> holder_r == ALL_ONES)
        else $error("reference short did not force ones");
    holder_stable_a: assert property (!capture |=> $stable(holder_r))
        else $error("holder changed without capture");
    blank_capture_a: assert property (blank_rise && load_sel == SEL_OPEN && !det_s2_r.thermal_shutdown
                                      |=> holder_r == ($past(det_s2_r.open_led_flag) & $past(onoff_r)))
        else $error("blank rise did not capture open result");
    lat_ctrl_a: assert property (lat_take && pin_s2_r.sclk |=> ctrl_lat_r == $past(shreg_r))
        else $error("control latch not written");
    onoff_hold_a: assert property (lat_take && pin_s2_r.sclk |=> $stable(onoff_r))
        else $error("control write changed on-off latch");
    new_data_a: assert property (sclk_rise |=> new_data_r)
        else $error("shift did not mark new data");
    serial_out_load_a: assert property (load_go |=> serial_out == $past(holder_r[15]))
        else $error("loaded status not on serial output");
    open_mask_a: assert property (capture && load_sel == SEL_OPEN && !det_s2_r.thermal_shutdown
                                  |=> (holder_r & ~$past(onoff_r)) == 16'h0000)
        else $error("open result set for an off channel");
    leak_mask_a: assert property (capture && load_sel == SEL_LEAK && !det_s2_r.ref_pin_short_flag
                                  |=> (holder_r & $past(onoff_r)) == 16'h0000)
        else $error("leak result set for an on channel");
    leak_word_a: assert property (capture && load_sel == SEL_LEAK && !cfg_idm_en_r
                                  && !det_s2_r.ref_pin_short_flag
                                  |=> holder_r == ($past(det_s2_r.leakage_flag) & ~$past(onoff_r)))
        else $error("leak result not taken per channel");

    // Main scenarios seen
    load_seen_c: cover property (load_go);
    idm_end_c: cover property (idm_end && capture);
    ctrl_write_c: cover property (lat_take && pin_s2_r.sclk);
    axi_write_c: cover property (wr_go ##[1:4] s_axi_bvalid && s_axi_bready);
endmodule

// ==== inc/fsr_pkg.sv ====
// Package for the fault status readback block: constants and types
package fsr_pkg;
    // ***************************************************
    // Widths, selects, reset values
    // ***************************************************
    localparam int              CH_NUM        = 16;
    localparam logic [1:0]      SEL_NONE      = 2'h0;
    localparam logic [1:0]      SEL_OPEN      = 2'h1;
    localparam logic [1:0]      SEL_SHORT     = 2'h2;
    localparam logic [1:0]      SEL_LEAK      = 2'h3;
    localparam int              CL_SEL_LO     = 7;
    localparam int              CL_THR_BIT    = 10;
    localparam logic [15:0]     CTRL_LAT_RST  = 16'h847f;
    localparam logic [15:0]     ONOFF_RST     = 16'h0000;
    localparam logic [15:0]     ALL_ONES      = 16'hffff;
    // ***************************************************
    // Register map and timing
    // ***************************************************
    localparam logic [7:0]      REG_CFG       = 8'h00;
    localparam logic [7:0]      REG_SHIFT     = 8'h04;
    localparam logic [7:0]      REG_LATCH     = 8'h08;
    localparam int              CFG_IDM_BIT   = 16;
    localparam int              IDM_TIME_NS   = 1000;
    localparam int              CLK_NS        = 25;
    localparam logic [15:0]     IDM_CYC_RST   = 16'((IDM_TIME_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0]      RESP_OKAY     = 2'h0;
    localparam logic [1:0]      RESP_SLVERR   = 2'h2;
    // ***************************************************
    // Carriers
    // ***************************************************
    typedef struct packed {
        logic sclk;
        logic serial_in;
        logic lat;
        logic blank;
    } fsr_pins_type;
    typedef struct packed {
        logic [15:0] open_led_flag;
        logic [15:0] shorted_led_flag;
        logic [15:0] leakage_flag;
        logic        thermal_shutdown;
        logic        thermal_warning_flag;
        logic        ref_pin_short_flag;
    } fsr_det_type;
    typedef enum logic [1:0] {
        IDM_IDLE = 2'b01,
        IDM_RUN  = 2'b10
    } fsr_idm_type;
endpackage

// ==== test/fsr_host_model.sv ====
// Host model: drives the serial link and blank pins, reads serial data back
module fsr_host_model (
    input  wire logic             core_clk,   // Core clock, paces the link
    input  wire logic             serial_out, // Serial data from the device
    output fsr_pkg::fsr_pins_type pins        // Link pins to the device
);
    timeunit 1ns;
    timeprecision 1ps;
    import fsr_pkg::*;

    // Link idles with clock low and no latch or blank
    initial pins = '0;

    // One half of the 200 ns link period
    task automatic half();
        repeat (4) @(posedge core_clk);
    endtask

    // Shift a word MSB first and capture what the device sends back
    task automatic shift_word(input logic [15:0] d, output logic [15:0] q);
        for (int i = 15; i >= 0; i--) begin
            pins.sclk <= 1'b0;
            pins.serial_in  <= d[i];
            half();
            q[i] = serial_out;
            pins.sclk <= 1'b1;
            half();
        end
        pins.serial_in <= ~d[0]; // Released data line does not keep its value
        @(posedge core_clk); // Next call's first bit lands in a later time step
    endtask

    // Latch pulse; clock high picks the control latch, low the on-off latch
    task automatic latch(input logic ctl);
        pins.sclk <= ctl;
        half();
        pins.lat <= 1'b1;
        half();
        pins.lat <= 1'b0;
        half();
        pins.sclk <= 1'b0;
        half();
    endtask

    // Blank pulse; its rising edge captures the status holder
    task automatic blank_pulse();
        pins.blank <= 1'b1;
        half();
        pins.blank <= 1'b0;
        half();
    endtask
endmodule

// ==== test/fsr_top_tb.sv ====
// Self-checking bench for the fault status readback block
module fsr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsr_pkg::*;

    logic         core_clk = 1'b0;
    logic         rst_n    = 1'b0;
    fsr_pins_type pins;
    fsr_det_type  det      = '0;
    logic         serial_out, short_threshold_select;
    logic [15:0]  channel_output;
    logic [7:0]   awaddr   = 8'h00;
    logic [7:0]   araddr   = 8'h00;
    logic [31:0]  wdata    = 32'h0, rdata;
    logic         awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [1:0]   bresp, rresp;
    integer       seed     = 63;
    int           failures = 0;
    int           n_tests  = 0;

    fsr_top uut (.core_clk(core_clk), .rst_n(rst_n), .pins(pins), .det(det), .serial_out(serial_out),
        .channel_output(channel_output), .short_threshold_select(short_threshold_select),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    fsr_host_model host (.core_clk(core_clk), .serial_out(serial_out), .pins(pins));

    // 40 MHz core clock
    initial forever #12.5 core_clk = ~core_clk;

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            $display("Error at %0t: got %h expected %h", $time, got, want);
            failures++;
        end
    endtask

    // Report counts, give the verdict and stop
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bus write; address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        @(posedge core_clk);
    endtask

    // Bus read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge core_clk);
    endtask

    // Expected status word for a select, detector state and on-off pattern
    function automatic logic [15:0] exp_stat(logic [1:0] s, fsr_det_type d, logic [15:0] on);
        case (s)
            SEL_OPEN:  return d.thermal_shutdown ? ALL_ONES : (d.open_led_flag & on);
            SEL_SHORT: return d.thermal_warning_flag ? ALL_ONES : (d.shorted_led_flag & on);
            default:   return d.ref_pin_short_flag ? ALL_ONES : (d.leakage_flag & ~on);
        endcase
    endfunction

    // New detector state, then a blank pulse to capture it
    task automatic capture(input logic [1:0] s, input logic [15:0] on, inout logic [15:0] hold);
        fsr_det_type dv;
        dv = fsr_det_type'({$random(seed), $random(seed)});
        dv.thermal_shutdown     = ($random(seed) & 3) == 0;
        dv.thermal_warning_flag = ($random(seed) & 3) == 0;
        dv.ref_pin_short_flag   = ($random(seed) & 3) == 0;
        det <= dv;
        repeat (4) @(posedge core_clk);
        host.blank_pulse();
        if (s != SEL_NONE) hold = exp_stat(s, dv, on);
    endtask

    // Watchdog
    initial begin
        #(25 * 60000);
        failures++;
        test_done();
    end

    // Main sequence
    initial begin
        logic [15:0] q, ctl, onoff, hold, shreg;
        logic [31:0] d;
        logic [1:0]  r, s;
        fsr_det_type dv;
        hold = 16'h0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        axi_rd(REG_CFG, d, r);
        chk(d, {16'h0000, IDM_CYC_RST});
        axi_wr(REG_CFG, 32'h0000_0030, r);
        chk(r, RESP_OKAY);
        axi_rd(REG_CFG, d, r);
        chk(d, 32'h0000_0030);
        axi_wr(REG_SHIFT, 32'hffff_ffff, r);
        chk(r, RESP_SLVERR);
        axi_rd(8'h0c, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        for (int k = 0; k < 24; k++) begin
            s = (k < 8) ? 2'(k + 1) : 2'($random(seed));
            ctl = 16'($random(seed));
            ctl[8:7] = s;
            onoff = 16'($random(seed));
            if (k < 8) onoff[15] = k[2];
            host.shift_word(ctl, q);
            host.latch(1'b1);
            chk(short_threshold_select, ctl[10]);
            host.shift_word(onoff, q);
            host.latch(1'b0);
            axi_rd(REG_LATCH, d, r);
            chk(d, {ctl, onoff});
            capture(s, onoff, hold);
            host.shift_word(onoff, q);
            host.latch(1'b0);
            chk(channel_output, onoff);
            shreg = (!onoff[15] && s != SEL_NONE) ? hold : onoff;
            axi_rd(REG_SHIFT, d, r);
            chk(d, {hold, shreg});
            capture(s, onoff, hold);
            host.latch(1'b0);
            axi_rd(REG_SHIFT, d, r);
            chk(d, {hold, shreg});
            host.shift_word(16'($random(seed)), q);
            chk(q, shreg);
        end
        // Invisible detection: capture at blank rise, then again at the end of the working time
        axi_wr(REG_CFG, 32'h0001_0010, r);
        chk(r, RESP_OKAY);
        ctl = 16'($random(seed));
        ctl[8:7] = SEL_OPEN;
        onoff = 16'($random(seed));
        host.shift_word(ctl, q);
        host.latch(1'b1);
        host.shift_word(onoff, q);
        host.latch(1'b0);
        capture(SEL_OPEN, onoff, hold);
        dv = fsr_det_type'({$random(seed), $random(seed)});
        det <= dv;
        axi_rd(REG_SHIFT, d, r);
        chk(r, RESP_OKAY);
        chk(d[31:16], hold);
        repeat (24) @(posedge core_clk);
        axi_rd(REG_SHIFT, d, r);
        chk(d[31:16], exp_stat(SEL_OPEN, dv, onoff));
        test_done();
    end
endmodule
